/* File: shared/fbp_pkg.sv */
package fbp_pkg;

    // Array geometry: 32 KB of 32-bit words, 1 KB erase blocks, 2 KB protection pairs.
    localparam int unsigned FBP_ADDR_W     = 15;
    localparam int unsigned FBP_DATA_W     = 32;
    localparam int unsigned FBP_WORD_LSB   = 2;
    localparam int unsigned FBP_WORD_W     = FBP_ADDR_W - FBP_WORD_LSB;
    localparam int unsigned FBP_NUM_WORDS  = 1 << FBP_WORD_W;
    localparam int unsigned FBP_BLK_LSB    = 10;
    localparam int unsigned FBP_BLK_W      = FBP_ADDR_W - FBP_BLK_LSB;
    localparam int unsigned FBP_OFS_W      = FBP_BLK_LSB - FBP_WORD_LSB;
    localparam int unsigned FBP_PAIR_LSB   = 11;
    localparam int unsigned FBP_PAIR_W     = FBP_ADDR_W - FBP_PAIR_LSB;
    localparam int unsigned FBP_NUM_PAIRS  = 1 << FBP_PAIR_W;

    localparam logic [FBP_DATA_W-1:0] FBP_ERASED    = 32'hFFFF_FFFF;
    localparam logic [FBP_DATA_W-1:0] FBP_ZERO      = 32'h0000_0000;
    localparam logic [FBP_OFS_W-1:0]  FBP_OFS_FIRST = 8'h00;
    localparam logic [FBP_OFS_W-1:0]  FBP_OFS_LAST  = 8'hFF;
    localparam logic [FBP_OFS_W-1:0]  FBP_OFS_STEP  = 8'h01;

    typedef enum logic [1:0] {
        FBP_OP_READ,
        FBP_OP_PROG,
        FBP_OP_ERASE
    } fbp_op_t;

    typedef enum logic [1:0] {
        FBP_SRC_FETCH,
        FBP_SRC_DATA,
        FBP_SRC_DEBUG
    } fbp_src_t;

    typedef enum logic [1:0] {
        FBP_PROT_NONE,
        FBP_PROT_RO,
        FBP_PROT_XO
    } fbp_prot_t;

    typedef struct packed {
        logic                  valid;
        fbp_op_t               op;
        fbp_src_t              src;
        logic [FBP_ADDR_W-1:0] addr;
        logic [FBP_DATA_W-1:0] wdata;
    } fbp_req_t;

    typedef struct packed {
        logic                  done;
        logic                  ok;
        logic [FBP_DATA_W-1:0] rdata;
    } fbp_rsp_t;

    typedef struct packed {
        logic                  we;
        logic [FBP_PAIR_W-1:0] pair;
        fbp_prot_t             mode;
    } fbp_cfg_t;

endpackage

/* File: hdl/fbp_array.sv */
`timescale 1ns/1ns
`default_nettype none

// Word array with one write port and one registered read port.
module fbp_array #(
    parameter int unsigned DATA_W = 32,
    parameter int unsigned WORD_W = 13
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              we_i,
    input  wire logic [WORD_W-1:0] waddr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic [WORD_W-1:0] raddr_i,
    output var  logic [DATA_W-1:0] rdata_o
);

    logic [DATA_W-1:0] mem [0:(1<<WORD_W)-1];

    // The cells themselves have no reset, as in a real array.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule // fbp_array

`default_nettype wire

/* File: hdl/fbp_gate.sv */
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - A 32 KB array is kept in 1 KB erase blocks, each erased alone without touching others.
// - After an erase completes every bit of the erased block reads as one.
// - Protection is held per 2 KB pair of blocks, each pair set read-only or execute-only.
// - A read-only pair refuses erase and program but still serves reads.
// - An execute-only pair refuses erase and program and serves reads to instruction fetch only.
module fbp_gate (
    input  wire logic                               clk_i,
    input  wire logic                               rst_b_i,
    input  wire fbp_pkg::fbp_req_t                  req_i,
    output var  logic                               ready_o,
    output var  fbp_pkg::fbp_rsp_t                  rsp_o,
    input  wire fbp_pkg::fbp_cfg_t                  cfg_i,
    output var  logic [fbp_pkg::FBP_NUM_PAIRS-1:0]  ro_o,
    output var  logic [fbp_pkg::FBP_NUM_PAIRS-1:0]  xo_o,
    input  wire logic                               viol_clr_i,
    output var  logic                               viol_o
);

    import fbp_pkg::*;

    typedef enum logic [1:0] {
        FBP_ST_IDLE,
        FBP_ST_READ,
        FBP_ST_PROG,
        FBP_ST_ERASE
    } fbp_state_t;

    typedef struct packed {
        fbp_state_t             st;
        logic                   ready;
        fbp_rsp_t               rsp;
        logic [FBP_WORD_W-1:0]  word;
        logic [FBP_DATA_W-1:0]  wdata;
        logic [FBP_BLK_W-1:0]   blk;
        logic [FBP_OFS_W-1:0]   ofs;
        logic [FBP_NUM_PAIRS-1:0] ro;
        logic [FBP_NUM_PAIRS-1:0] xo;
        logic                   viol;
    } fbp_gate_state_t;

    fbp_gate_state_t q;
    fbp_gate_state_t d;

    logic                  arr_we;
    logic [FBP_WORD_W-1:0] arr_waddr;
    logic [FBP_DATA_W-1:0] arr_wdata;
    logic [FBP_WORD_W-1:0] arr_raddr;
    logic [FBP_DATA_W-1:0] arr_rdata;

    function automatic logic [FBP_PAIR_W-1:0] pair_of(input logic [FBP_ADDR_W-1:0] a);
        return a[FBP_ADDR_W-1:FBP_PAIR_LSB];
    endfunction

    function automatic logic [FBP_WORD_W-1:0] word_of(input logic [FBP_ADDR_W-1:0] a);
        return a[FBP_ADDR_W-1:FBP_WORD_LSB];
    endfunction

    function automatic logic allowed(input fbp_req_t r,
                                     input logic [FBP_NUM_PAIRS-1:0] ro,
                                     input logic [FBP_NUM_PAIRS-1:0] xo);
        logic ro_hit;
        logic xo_hit;
        ro_hit = ro[pair_of(r.addr)];
        xo_hit = xo[pair_of(r.addr)];
        if (r.op == FBP_OP_READ) begin
            return !(xo_hit && (r.src != FBP_SRC_FETCH));
        end
        return !(ro_hit || xo_hit);
    endfunction

    fbp_array #(
        .DATA_W (FBP_DATA_W),
        .WORD_W (FBP_WORD_W)
    ) u_array (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .we_i    (arr_we),
        .waddr_i (arr_waddr),
        .wdata_i (arr_wdata),
        .raddr_i (arr_raddr),
        .rdata_o (arr_rdata)
    );

    always_comb begin
        logic accept;
        logic viol_set;
        d         = q;
        accept    = 1'b0;
        viol_set  = 1'b0;
        arr_we    = 1'b0;
        arr_waddr = q.word;
        arr_wdata = q.wdata;
        arr_raddr = q.word;
        d.rsp.done = 1'b0;

        // Protection only tightens; a pair once protected stays so until reset,
        // so running code cannot unlock itself.
        if (cfg_i.we) begin
            if (cfg_i.mode == FBP_PROT_RO) begin
                d.ro[cfg_i.pair] = 1'b1;
            end else if (cfg_i.mode == FBP_PROT_XO) begin
                d.xo[cfg_i.pair] = 1'b1;
            end
        end

        case (q.st)
            FBP_ST_IDLE: begin
                accept = req_i.valid && q.ready;
                if (accept) begin
                    arr_raddr = word_of(req_i.addr);
                    d.word    = word_of(req_i.addr);
                    d.wdata   = req_i.wdata;
                    if (!allowed(req_i, q.ro, q.xo)) begin
                        // Nothing is written to the array; of the outputs, only the flag and the answer move.
                        viol_set    = 1'b1;
                        d.rsp.done  = 1'b1;
                        d.rsp.ok    = 1'b0;
                        d.rsp.rdata = FBP_ZERO;
                    end else begin
                        d.ready = 1'b0;
                        case (req_i.op)
                            FBP_OP_READ: begin
                                d.st = FBP_ST_READ;
                            end
                            FBP_OP_PROG: begin
                                d.st = FBP_ST_PROG;
                            end
                            FBP_OP_ERASE: begin
                                d.st  = FBP_ST_ERASE;
                                d.blk = req_i.addr[FBP_ADDR_W-1:FBP_BLK_LSB];
                                d.ofs = FBP_OFS_FIRST;
                            end
                            default: begin
                                d.ready     = 1'b1;
                                viol_set    = 1'b1;
                                d.rsp.done  = 1'b1;
                                d.rsp.ok    = 1'b0;
                                d.rsp.rdata = FBP_ZERO;
                            end
                        endcase
                    end
                end
            end
            FBP_ST_READ: begin
                d.st        = FBP_ST_IDLE;
                d.ready     = 1'b1;
                d.rsp.done  = 1'b1;
                d.rsp.ok    = 1'b1;
                d.rsp.rdata = arr_rdata;
            end
            FBP_ST_PROG: begin
                // Programming can only clear bits, so the old word is merged in.
                arr_we      = 1'b1;
                arr_waddr   = q.word;
                arr_wdata   = arr_rdata & q.wdata;
                d.st        = FBP_ST_IDLE;
                d.ready     = 1'b1;
                d.rsp.done  = 1'b1;
                d.rsp.ok    = 1'b1;
                d.rsp.rdata = FBP_ZERO;
            end
            FBP_ST_ERASE: begin
                // One word a cycle; only words inside the chosen block are written.
                arr_we    = 1'b1;
                arr_waddr = {q.blk, q.ofs};
                arr_wdata = FBP_ERASED;
                d.ofs     = q.ofs + FBP_OFS_STEP;
                if (q.ofs == FBP_OFS_LAST) begin
                    d.st        = FBP_ST_IDLE;
                    d.ready     = 1'b1;
                    d.rsp.done  = 1'b1;
                    d.rsp.ok    = 1'b1;
                    d.rsp.rdata = FBP_ZERO;
                end
            end
            default: begin
                d.st    = FBP_ST_IDLE;
                d.ready = 1'b1;
            end
        endcase

        // A violation in the cycle of a clear still leaves the flag set.
        d.viol = (q.viol && !viol_clr_i) || viol_set;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q       <= '0;
            q.st    <= FBP_ST_IDLE;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign ready_o = q.ready;
    assign rsp_o   = q.rsp;
    assign ro_o    = q.ro;
    assign xo_o    = q.xo;
    assign viol_o  = q.viol;

endmodule // fbp_gate

`default_nettype wire

/* File: verification/fbp_host.sv */
`timescale 1ns/1ns
`default_nettype none

// Stand-in for the fetch, data and debug requesters; one request in flight.
module fbp_host (
    input  wire logic              clk_i,
    input  wire logic              ready_i,
    output var  fbp_pkg::fbp_req_t req_o
);
    import fbp_pkg::*;

    initial req_o = '0;

    task automatic issue(input fbp_op_t op, input fbp_src_t src, input logic [14:0] a,
                         input logic [31:0] d);
        @(posedge clk_i);
        req_o <= '{1'b1, op, src, a, d};
        do @(posedge clk_i); while (ready_i !== 1'b1);
        // Released address and data carry inverted junk so nothing can lean on stale values.
        req_o <= '{1'b0, op, src, ~a, ~d};
    endtask
endmodule // fbp_host

`default_nettype wire

/* File: verification/fbp_gate_properties.sv */
`timescale 1ns/1ns
`default_nettype none

module fbp_chk
    import fbp_pkg::*;
(
    input wire logic                              clk_i,
    input wire logic                              rst_b_i,
    input wire fbp_pkg::fbp_req_t                 req_i,
    input wire logic                              ready_o,
    input wire fbp_pkg::fbp_rsp_t                 rsp_o,
    input wire fbp_pkg::fbp_cfg_t                 cfg_i,
    input wire logic [fbp_pkg::FBP_NUM_PAIRS-1:0] ro_o,
    input wire logic [fbp_pkg::FBP_NUM_PAIRS-1:0] xo_o,
    input wire logic                              viol_clr_i,
    input wire logic                              viol_o
);
    wire logic [3:0] p = req_i.addr[14:11];
    wire logic tk = req_i.valid && ready_o;
    wire logic bad = tk && ((req_i.op == FBP_OP_READ) ? (xo_o[p] && req_i.src != FBP_SRC_FETCH)
                                                      : (ro_o[p] || xo_o[p]));
    wire logic rd = tk && !bad && req_i.op == FBP_OP_READ;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_ref; bad |=> rsp_o.done && !rsp_o.ok && rsp_o.rdata == FBP_ZERO && viol_o; endproperty
    property p_rd; rd |=> !ready_o ##1 rsp_o.done && rsp_o.ok; endproperty
    property p_pg; tk && !bad && req_i.op == FBP_OP_PROG |-> ##2 rsp_o.done && rsp_o.ok; endproperty
    property p_er;
        tk && !bad && req_i.op == FBP_OP_ERASE |=> !ready_o [*8] ##249 rsp_o.done && rsp_o.ok;
    endproperty
    property p_stk; viol_o && !viol_clr_i |=> viol_o; endproperty
    property p_clr; viol_clr_i && !bad |=> !viol_o; endproperty
    property p_cfg; cfg_i.we && cfg_i.mode == FBP_PROT_XO |=> xo_o[$past(cfg_i.pair)]; endproperty
    property p_mono; 1'b1 |=> ((ro_o & $past(ro_o)) == $past(ro_o)) && ((xo_o & $past(xo_o)) == $past(xo_o)); endproperty

    a_ref: assert property (p_ref) else $error("refused request answered wrongly");
    a_rd: assert property (p_rd) else $error("read not served in two cycles");
    a_pg: assert property (p_pg) else $error("program not served in two cycles");
    a_er: assert property (p_er) else $error("erase not done in 257 cycles");
    a_stk: assert property (p_stk) else $error("violation flag lost");
    a_clr: assert property (p_clr) else $error("violation flag not cleared");
    a_cfg: assert property (p_cfg) else $error("execute-only bit not set");
    a_mono: assert property (p_mono) else $error("protection bit dropped");

    c_ref: cover property (bad);
    c_er: cover property (tk && req_i.op == FBP_OP_ERASE);
    c_xo: cover property (rd && xo_o[p]);
    c_both: cover property (bad && viol_clr_i);
endmodule // fbp_chk

bind fbp_gate fbp_chk u_chk (.clk_i, .rst_b_i, .req_i, .ready_o, .rsp_o, .cfg_i, .ro_o, .xo_o,
                             .viol_clr_i, .viol_o);

`default_nettype wire

/* File: verification/flash_block_erase_protection_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module flash_block_erase_protection_bench;
    import fbp_pkg::*;

    logic                     clk_i = 1'b0;
    logic                     rst_b_i = 1'b0;
    logic                     viol_clr_i = 1'b0;
    logic                     ready_o, viol_o;
    logic [FBP_NUM_PAIRS-1:0] ro_o, xo_o, ro, xo;
    fbp_req_t                 req_i;
    fbp_rsp_t                 rsp_o;
    fbp_cfg_t                 cfg_i = '0;
    logic [31:0]              m [int];
    logic [32:0]              q [$];
    int                       error_cnt = 0;
    int                       checked = 0;
    int                       n = 0;

    initial forever #5 clk_i = ~clk_i;

    fbp_host host (.clk_i(clk_i), .ready_i(ready_o), .req_o(req_i));
    fbp_gate DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .ready_o(ready_o),
                  .rsp_o(rsp_o), .cfg_i(cfg_i), .ro_o(ro_o), .xo_o(xo_o),
                  .viol_clr_i(viol_clr_i), .viol_o(viol_o));

    task automatic cmp(input logic [32:0] g, input logic [32:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_rsp(input logic [32:0] g, input logic [32:0] e);
        cmp(g, e);
    endtask

    task automatic cmp_prot(input logic [32:0] g, input logic [32:0] e);
        cmp(g, e);
    endtask

    task automatic cmp_flag(input logic g, input logic e);
        cmp({32'h0, g}, {32'h0, e});
    endtask

    function automatic logic [32:0] predict(input fbp_op_t op, input fbp_src_t src,
                                            input logic [14:0] a, input logic [31:0] d);
        logic [3:0] p;
        p = a[14:11];
        if ((op == FBP_OP_READ) ? (xo[p] && src != FBP_SRC_FETCH) : (ro[p] | xo[p]))
            return {1'b0, FBP_ZERO};
        if (op == FBP_OP_ERASE)
            for (int i = 0; i < 256; i++) m[{a[14:10], i[7:0]}] = FBP_ERASED;
        if (op == FBP_OP_PROG) m[a[14:2]] = m[a[14:2]] & d;
        return {1'b1, (op == FBP_OP_READ) ? m[a[14:2]] : FBP_ZERO};
    endfunction

    task automatic tx(input fbp_op_t op, input fbp_src_t src, input logic [14:0] a,
                      input logic [31:0] d);
        q.push_back(predict(op, src, a, d));
        host.issue(op, src, a, d);
    endtask

    // A done with nothing noted is compared against unknown, so it always counts as wrong.
    always @(negedge clk_i) begin
        if (rsp_o.done === 1'b1) begin
            cmp_rsp({rsp_o.ok, rsp_o.rdata}, q.size() ? q.pop_front() : 33'hX);
        end
    end

    task automatic idle;
        for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge clk_i);
        // A note still waiting here means an answer never came, which must not pass quietly.
        if (q.size() != 0) cmp_rsp(33'(q.size()), 33'h0);
        repeat (2) @(posedge clk_i);
    endtask

    task automatic prot(input logic [3:0] p, input fbp_prot_t md);
        idle();
        cfg_i <= '{1'b1, p, md};
        @(posedge clk_i);
        cfg_i.we <= 1'b0;
        ro[p] |= (md == FBP_PROT_RO);
        xo[p] |= (md == FBP_PROT_XO);
        @(negedge clk_i);
        cmp_prot({1'b0, ro_o, xo_o}, {1'b0, ro, xo});
    endtask

    task automatic viol(input logic e, input string s);
        idle();
        // The flag is looked at mid-cycle, away from the edge that may move it.
        @(negedge clk_i);
        cmp_flag(viol_o, e);
        @(posedge clk_i);
        viol_clr_i <= 1'b1;
        @(posedge clk_i);
        viol_clr_i <= 1'b0;
        @(negedge clk_i);
        cmp_flag(viol_o, 1'b0);
        n++;
        $display("Test %0d ended: %s", n, s);
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // The tests need about a thousand cycles; twenty times that means a hang.
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        stop_test();
    end

    initial begin
        logic [14:0] a;
        logic [31:0] d;
        void'($urandom(32'h0632));
        ro = '0;
        xo = '0;
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
        cmp_prot({ready_o, ro_o, xo_o}, {1'b1, 32'h0});
        for (int b = 0; b < 3; b++) tx(FBP_OP_ERASE, FBP_SRC_DATA, 15'(b << 10), '0);
        a = {5'h01, 8'($urandom()), 2'h0};
        d = $urandom();
        tx(FBP_OP_PROG, FBP_SRC_DATA, a, d);
        tx(FBP_OP_PROG, FBP_SRC_DEBUG, a, ~d | 32'h1);
        tx(FBP_OP_READ, FBP_SRC_DATA, a, '0);
        tx(FBP_OP_READ, FBP_SRC_DEBUG, a ^ 15'h0400, '0);
        tx(FBP_OP_PROG, FBP_SRC_DATA, a ^ 15'h0400, d);
        tx(FBP_OP_ERASE, FBP_SRC_DEBUG, a, '0);
        tx(FBP_OP_READ, FBP_SRC_FETCH, a, '0);
        // The neighbouring block keeps its programmed word through the erase.
        tx(FBP_OP_READ, FBP_SRC_DATA, a ^ 15'h0400, '0);
        viol(1'b0, "erase and program");
        prot(4'h0, FBP_PROT_RO);
        tx(FBP_OP_PROG, FBP_SRC_DATA, a, '0);
        tx(FBP_OP_ERASE, FBP_SRC_DEBUG, a, '0);
        tx(FBP_OP_READ, FBP_SRC_DEBUG, a, '0);
        viol(1'b1, "read-only pair");
        prot(4'h1, FBP_PROT_XO);
        prot(4'h2, FBP_PROT_NONE);
        for (int s = 0; s < 3; s++)
            tx(FBP_OP_READ, fbp_src_t'(s), 15'h0800 | 15'($urandom() & 32'h3FC), '0);
        viol(1'b1, "execute-only pair");
        // A refusal taken in the very cycle of a clear must leave the flag set.
        fork
            tx(FBP_OP_PROG, FBP_SRC_FETCH, 15'h0A00, '0);
            begin
                @(posedge clk_i);
                viol_clr_i <= 1'b1;
                @(posedge clk_i);
                viol_clr_i <= 1'b0;
            end
        join
        viol(1'b1, "refusal beats clear");
        stop_test();
    end
endmodule // flash_block_erase_protection_bench

`default_nettype wire
